// ===== hdl/ptb_pkg.sv
// Constants, register map and types shared by the time base files.
// Functional notes
// - The time base is a 15-bit counter stepped through an input prescaler, with a postscaler on its event output, and software can read the count.
// - The top bit of the count register is a read-only direction flag, zero while counting up and one while counting down.
// - Setting the enable starts counting, clearing it stops counting, and a software clear leaves the count untouched.
// - When the low 15 count bits reach the period, the next step either returns the count to zero or turns the direction, by mode.
// - A period of zero stops the counter and suppresses every interrupt and trigger event.
// - While the active period is zero no new period is loaded, so software must disable the time base to change it.
// - A 2-bit mode field picks free-running, single-shot, continuous up/down, or up/down with double updates.
// - The mode field together with the 4-bit postscale field decides which interrupt events are produced.
// - In free-running mode the counter counts up to the period, returns to zero on the next step and repeats while enabled.
// - In free-running mode each wrap to zero at a period match is an interrupt event that the postscaler may thin out.
// - In single-shot mode the counter counts up when enabled, returns to zero after the match and hardware clears the enable.
// - In single-shot mode one interrupt event is raised at the match and wrap, and the postscaler has no effect.
// - In continuous up/down mode the counter turns down after the period and raises a postscalable event when it reaches zero.
// - In double-update mode an event is raised both at zero and at every period match, with no postscaling.
// - The counter clock is prescaled by 1, 4, 16 or 64, and the prescaler is cleared by a count or control write or reset.
// - The event output passes a 4-bit postscaler dividing by 1 to 16, cleared by a count or control write or reset.

package ptb_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CNT_W = 15;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int PRE_W = 6;
  localparam int POST_W = 4;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTL_EN_BIT = 15;
  localparam int CTL_OPS_LSB = 4;
  localparam int CTL_CKPS_LSB = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam int COUNT_DIR_BIT = 15;
  localparam int INT_TB_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;
  localparam logic [CNT_W-1:0] PER_RST = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [POST_W-1:0] POST_RST = 4'h0;
  localparam logic [PRE_W-1:0] PRE_RST = 6'h00;

  // ----------------------------------------------------------------------
  // Prescaler terminal counts for 1:1, 1:4, 1:16 and 1:64
  // ----------------------------------------------------------------------
  localparam logic [PRE_W-1:0] PRE_LIM_1 = 6'h00;
  localparam logic [PRE_W-1:0] PRE_LIM_4 = 6'h03;
  localparam logic [PRE_W-1:0] PRE_LIM_16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_LIM_64 = 6'h3f;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PTB_MODE_FREE = 2'h0,
    PTB_MODE_SINGLE = 2'h1,
    PTB_MODE_UPDOWN = 2'h2,
    PTB_MODE_DOUBLE = 2'h3
  } ptb_mode_t;

  typedef enum logic [1:0]
  {
    PTB_UP = 2'b01,
    PTB_DOWN = 2'b10
  } ptb_dir_t;

endpackage : ptb_pkg

// ===== hdl/ptb_postscaler.sv
// Event postscaler passing one of every 1 to 16 events.
`timescale 1ns/1ns

module ptb_postscaler
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic [POST_W-1:0] sel_in,
  // Events
  input wire logic event_in,
  output logic event_out
);

  logic [POST_W-1:0] cnt_q;
  logic [POST_W-1:0] cnt_d;

  // Pass the event whose count equals the select, then start over.
  always_comb
  begin
    event_out = event_in && !clear_in && (cnt_q == sel_in);
    cnt_d = cnt_q;
    if (clear_in || event_out)
      cnt_d = POST_RST;
    else if (event_in)
      cnt_d = POST_W'(cnt_q + 1'b1);
  end

  // Postscaler count register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      cnt_q <= POST_RST;
    else
      cnt_q <= cnt_d;
  end

endmodule : ptb_postscaler

// ===== hdl/ptb_prescaler.sv
// Input prescaler that turns the clock into counter steps.
`timescale 1ns/1ns

module ptb_prescaler
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic [1:0] sel_in,
  // Step pulse
  output logic tick_out
);

  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] cnt_d;
  logic [PRE_W-1:0] limit;

  // Terminal count from the ratio select; a step fires at the limit.
  always_comb
  begin
    unique case (sel_in)
      2'h0: limit = PRE_LIM_1;
      2'h1: limit = PRE_LIM_4;
      2'h2: limit = PRE_LIM_16;
      default: limit = PRE_LIM_64;
    endcase
    tick_out = !clear_in && (cnt_q == limit);
    if (clear_in || tick_out)
      cnt_d = PRE_RST;
    else
      cnt_d = PRE_W'(cnt_q + 1'b1);
  end

  // Prescaler count register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      cnt_q <= PRE_RST;
    else
      cnt_q <= cnt_d;
  end

endmodule : ptb_prescaler

// ===== hdl/ptb_top.sv
// Time base of a motor-control PWM unit with register port and interrupt.
`timescale 1ns/1ns

module ptb_top
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rd_data_out,
  // Interrupt
  output logic irq_out,
  // Time base state for the comparators
  output logic [CNT_W-1:0] time_base_count_out,
  output logic count_direction_flag_out,
  output logic period_match_out,
  output logic count_zero_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic time_base_enable_q;
  logic time_base_enable_d;
  ptb_mode_t time_base_mode_select_q;
  ptb_mode_t time_base_mode_select_d;
  logic [1:0] input_prescale_select_q;
  logic [1:0] input_prescale_select_d;
  logic [POST_W-1:0] output_postscale_select_q;
  logic [POST_W-1:0] output_postscale_select_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  ptb_dir_t dir_q;
  ptb_dir_t dir_d;
  logic [CNT_W-1:0] period_buf_q;
  logic [CNT_W-1:0] period_buf_d;
  logic [CNT_W-1:0] period_value_q;
  logic [CNT_W-1:0] period_value_d;
  logic int_status_q;
  logic int_status_d;
  logic int_mask_q;
  logic int_mask_d;
  logic irq_q;
  logic irq_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic match_q;
  logic zero_q;

  // ----------------------------------------------------------------------
  // Decode and events
  // ----------------------------------------------------------------------
  logic ctl_wr;
  logic cnt_wr;
  logic per_wr;
  logic sts_wr;
  logic msk_wr;
  logic tick;
  logic step;
  logic at_per;
  logic wrap;
  logic turn_down;
  logic zero_evt;
  logic post_in;
  logic post_out;
  logic direct_evt;
  logic tb_event;
  logic per_load;

  // Write strobes per register.
  assign ctl_wr = wr_in && (addr_in == ADDR_CONTROL);
  assign cnt_wr = wr_in && (addr_in == ADDR_COUNT);
  assign per_wr = wr_in && (addr_in == ADDR_PERIOD);
  assign sts_wr = wr_in && (addr_in == ADDR_INT_STATUS);
  assign msk_wr = wr_in && (addr_in == ADDR_INT_MASK);

  // The prescaler also restarts while disabled, so a fresh enable waits a full ratio.
  ptb_prescaler u_prescaler
  (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clear_in(ctl_wr || cnt_wr || !time_base_enable_q),
    .sel_in(input_prescale_select_q),
    .tick_out(tick)
  );

  // A zero period stops all stepping and thus every event.
  assign step = tick && time_base_enable_q && (period_value_q != PER_RST);
  // Greater-or-equal keeps the counter from running away after a period shrink.
  assign at_per = (cnt_q >= period_value_q);

  // ----------------------------------------------------------------------
  // Counter, direction and enable
  // ----------------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    time_base_enable_d = time_base_enable_q;
    wrap = 1'b0;
    turn_down = 1'b0;
    zero_evt = 1'b0;
    if (ctl_wr)
      time_base_enable_d = wr_data_in[CTL_EN_BIT];
    if (cnt_wr)
      cnt_d = wr_data_in[CNT_W-1:0];
    else if (step)
    begin
      if (time_base_mode_select_q == PTB_MODE_FREE || time_base_mode_select_q == PTB_MODE_SINGLE)
      begin
        if (at_per)
        begin
          cnt_d = CNT_RST;
          wrap = 1'b1;
          // A software write in the same cycle keeps its own enable value.
          if (time_base_mode_select_q == PTB_MODE_SINGLE && !ctl_wr)
            time_base_enable_d = 1'b0;
        end
        else
          cnt_d = CNT_W'(cnt_q + CNT_ONE);
      end
      else
      begin
        unique case (dir_q)
          PTB_UP:
          begin
            if (at_per)
            begin
              dir_d = PTB_DOWN;
              cnt_d = CNT_W'(cnt_q - CNT_ONE);
              turn_down = 1'b1;
            end
            else
              cnt_d = CNT_W'(cnt_q + CNT_ONE);
          end
          PTB_DOWN:
          begin
            if (cnt_q <= CNT_ONE)
            begin
              dir_d = PTB_UP;
              cnt_d = CNT_RST;
              zero_evt = 1'b1;
            end
            else
              cnt_d = CNT_W'(cnt_q - CNT_ONE);
          end
          default:
          begin
            dir_d = PTB_UP;
            cnt_d = CNT_RST;
          end
        endcase
      end
    end
  end

  // Counter registers.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q <= CNT_RST;
      dir_q <= PTB_UP;
      time_base_enable_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      time_base_enable_q <= time_base_enable_d;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration and period
  // ----------------------------------------------------------------------
  // The period loads at a wrap or at zero, and freely while disabled, but never
  // out of a zero period while running.
  assign per_load = !time_base_enable_q ||
                    ((period_value_q != PER_RST) && (wrap || zero_evt));

  always_comb
  begin
    time_base_mode_select_d = time_base_mode_select_q;
    input_prescale_select_d = input_prescale_select_q;
    output_postscale_select_d = output_postscale_select_q;
    period_buf_d = period_buf_q;
    period_value_d = period_value_q;
    if (ctl_wr)
    begin
      time_base_mode_select_d = ptb_mode_t'(wr_data_in[CTL_MODE_LSB +: 2]);
      input_prescale_select_d = wr_data_in[CTL_CKPS_LSB +: 2];
      output_postscale_select_d = wr_data_in[CTL_OPS_LSB +: POST_W];
    end
    if (per_wr)
      period_buf_d = wr_data_in[CNT_W-1:0];
    if (per_load)
      period_value_d = period_buf_q;
  end

  // Configuration registers.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      time_base_mode_select_q <= PTB_MODE_FREE;
      input_prescale_select_q <= 2'h0;
      output_postscale_select_q <= POST_RST;
      period_buf_q <= PER_RST;
      period_value_q <= PER_RST;
    end
    else
    begin
      time_base_mode_select_q <= time_base_mode_select_d;
      input_prescale_select_q <= input_prescale_select_d;
      output_postscale_select_q <= output_postscale_select_d;
      period_buf_q <= period_buf_d;
      period_value_q <= period_value_d;
    end
  end

  // ----------------------------------------------------------------------
  // Event routing and postscaler
  // ----------------------------------------------------------------------
  // Free-running wraps and up/down zeros are postscaled; single-shot wraps and double-update zeros and matches go direct.
  assign post_in = (time_base_mode_select_q == PTB_MODE_FREE && wrap) ||
                   (time_base_mode_select_q == PTB_MODE_UPDOWN && zero_evt);
  assign direct_evt = (time_base_mode_select_q == PTB_MODE_SINGLE && wrap) ||
                      (time_base_mode_select_q == PTB_MODE_DOUBLE && (zero_evt || turn_down));

  ptb_postscaler u_postscaler
  (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clear_in(ctl_wr || cnt_wr),
    .sel_in(output_postscale_select_q),
    .event_in(post_in),
    .event_out(post_out)
  );

  assign tb_event = post_out || direct_evt;

  // ----------------------------------------------------------------------
  // Interrupt and register read
  // ----------------------------------------------------------------------
  always_comb
  begin
    int_mask_d = int_mask_q;
    if (msk_wr)
      int_mask_d = wr_data_in[INT_TB_BIT];
    // A set in the clearing cycle wins so no event is lost.
    int_status_d = (int_status_q && !(sts_wr && wr_data_in[INT_TB_BIT])) || tb_event;
    irq_d = int_status_d && int_mask_d;
    rd_data_d = DATA_ZERO;
    if (rd_in)
    begin
      unique case (addr_in)
        ADDR_CONTROL:
        begin
          rd_data_d[CTL_EN_BIT] = time_base_enable_q;
          rd_data_d[CTL_OPS_LSB +: POST_W] = output_postscale_select_q;
          rd_data_d[CTL_CKPS_LSB +: 2] = input_prescale_select_q;
          rd_data_d[CTL_MODE_LSB +: 2] = time_base_mode_select_q;
        end
        ADDR_COUNT:
        begin
          rd_data_d[CNT_W-1:0] = cnt_q;
          rd_data_d[COUNT_DIR_BIT] = (dir_q == PTB_DOWN);
        end
        ADDR_PERIOD: rd_data_d[CNT_W-1:0] = period_buf_q;
        ADDR_INT_STATUS: rd_data_d[INT_TB_BIT] = int_status_q;
        ADDR_INT_MASK: rd_data_d[INT_TB_BIT] = int_mask_q;
        default: rd_data_d = DATA_ZERO;
      endcase
    end
  end

  // Interrupt, read data and event output registers.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      int_status_q <= 1'b0;
      int_mask_q <= 1'b0;
      irq_q <= 1'b0;
      rd_data_q <= DATA_ZERO;
      match_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else
    begin
      int_status_q <= int_status_d;
      int_mask_q <= int_mask_d;
      irq_q <= irq_d;
      rd_data_q <= rd_data_d;
      match_q <= wrap || turn_down;
      zero_q <= wrap || zero_evt;
    end
  end

  assign rd_data_out = rd_data_q;
  assign irq_out = irq_q;
  assign time_base_count_out = cnt_q;
  assign count_direction_flag_out = (dir_q == PTB_DOWN);
  assign period_match_out = match_q;
  assign count_zero_out = zero_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_count_readback: assert property ((rd_in && addr_in == ADDR_COUNT) |=>
    rd_data_out == {$past(dir_q) == PTB_DOWN, $past(cnt_q)})
    else $error("count read does not show count and direction");

  a_hold_disabled: assert property ((!time_base_enable_q && !cnt_wr) |=> $stable(cnt_q))
    else $error("count moved while disabled");

  a_zero_period_quiet: assert property ((period_value_q == PER_RST && !cnt_wr) |=>
    ($stable(cnt_q) && !match_q && !zero_q))
    else $error("zero period still counts or signals");

  a_period_stuck: assert property ((period_value_q == PER_RST && time_base_enable_q) |=>
    period_value_q == PER_RST)
    else $error("zero period reloaded while running");

  a_free_wrap: assert property ((step && !cnt_wr && at_per && time_base_mode_select_q == PTB_MODE_FREE) |=>
    (cnt_q == CNT_RST && time_base_enable_q == $past(time_base_enable_d) && zero_q))
    else $error("free-running wrap missing");

  a_single_halt: assert property ((step && !cnt_wr && !ctl_wr && at_per &&
    time_base_mode_select_q == PTB_MODE_SINGLE) |=> (cnt_q == CNT_RST && !time_base_enable_q && int_status_q))
    else $error("single-shot did not halt with event");

  a_updown_turn: assert property ((step && !cnt_wr && at_per && dir_q == PTB_UP &&
    time_base_mode_select_q == PTB_MODE_UPDOWN) |=> (dir_q == PTB_DOWN && match_q))
    else $error("up/down did not turn at period");

  a_double_event: assert property ((turn_down && time_base_mode_select_q == PTB_MODE_DOUBLE) |=>
    int_status_q ##1 (irq_out == (int_status_q && int_mask_q)))
    else $error("double-update match event missing");

  a_flag_sticky: assert property ((int_status_q && !(sts_wr && wr_data_in[INT_TB_BIT])) |=>
    int_status_q [*1])
    else $error("interrupt flag dropped without a clear");

  a_post_clear: assert property ((ctl_wr && time_base_mode_select_q == PTB_MODE_FREE) |=>
    (u_postscaler.cnt_q == POST_RST))
    else $error("postscaler count not cleared by control write");

endmodule : ptb_top

// ===== verification/ptb_testbench.sv
// Self-checking testbench for the PWM time base block.
`timescale 1ns/1ns

module testbench
  import ptb_pkg::*;
;
  // ----------------------------------------------------------------------
  // Design signals and counters
  // ----------------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wr_data_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rd_data_out;
  logic irq_out;
  logic [CNT_W-1:0] count_q;
  logic dir_q;
  logic match_w;
  logic zero_w;
  int failures = 0;
  int cmp_count = 0;

  // The clock toggles every half period of 10 ns.
  always #10 ref_clk_in = ~ref_clk_in;

  ptb_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
    .time_base_count_out(count_q), .count_direction_flag_out(dir_q), .period_match_out(match_w),
    .count_zero_out(zero_w));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Compares two 16-bit values with case equality so unknowns never match.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One write cycle; the strobe drops at the next edge, so calls never collide.
  // It returns just past that edge, so callers see outputs that the write has settled.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr

  // One read cycle; data are taken in the single cycle after the read edge.
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, exp, rd_data_out);
  endtask : rd_chk

  // Waits, bounded, until the count and direction reach the given pair.
  task automatic wait_cnt(input logic [14:0] c, input logic d);
    int n;
    n = 0;
    while (!(count_q === c && dir_q === d) && n < 600)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    chk("count reached", {d, c}, {dir_q, count_q});
  endtask : wait_cnt

  // Checks the count and direction after the next clock edge.
  task automatic step_chk(input logic [14:0] c, input logic d);
    @(posedge ref_clk_in);
    #1;
    chk("count step", {d, c}, {dir_q, count_q});
  endtask : step_chk

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Every register reads zero after reset, an unmapped address as well.
  task automatic t_reset();
    rd_chk("control", ADDR_CONTROL, 16'h0000);
    rd_chk("count", ADDR_COUNT, 16'h0000);
    rd_chk("period", ADDR_PERIOD, 16'h0000);
    rd_chk("status", ADDR_INT_STATUS, 16'h0000);
    rd_chk("mask", ADDR_INT_MASK, 16'h0000);
    rd_chk("unmapped", 8'h40, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq_out});
  endtask : t_reset

  // Free-running wrap, sticky flag with mask, disable keeps the count.
  task automatic t_free();
    logic [14:0] held;
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_CONTROL, 16'h8000);
    wait_cnt(15'h0001, 1'b0);
    for (int i = 0; i < 8; i++)
      step_chk(15'((i + 2) % 4), 1'b0);
    rd_chk("status free", ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_INT_MASK, 16'h0001);
    chk("irq on", 16'h0001, {15'h0000, irq_out});
    wr(ADDR_CONTROL, 16'h0000);
    held = count_q;
    repeat (6) @(posedge ref_clk_in);
    rd_chk("count held", ADDR_COUNT, {1'b0, held});
    wr(ADDR_INT_STATUS, 16'h0001);
    rd_chk("status cleared", ADDR_INT_STATUS, 16'h0000);
    @(posedge ref_clk_in);
    #1;
    chk("irq off", 16'h0000, {15'h0000, irq_out});
    wr(ADDR_COUNT, 16'h8002);
    rd_chk("direction read only", ADDR_COUNT, 16'h0002);
  endtask : t_free

  // Single shot halts itself; the largest postscale must not hide the event.
  task automatic t_single();
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_PERIOD, 16'h0002);
    wr(ADDR_CONTROL, 16'h80f1);
    repeat (14) @(posedge ref_clk_in);
    rd_chk("enable cleared", ADDR_CONTROL, 16'h00f1);
    rd_chk("count wrapped", ADDR_COUNT, 16'h0000);
    rd_chk("status single", ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_INT_STATUS, 16'h0001);
  endtask : t_single

  // Each prescale code sets the spacing of count steps.
  task automatic t_presc();
    int n;
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CONTROL, 16'h0000);
      wr(ADDR_COUNT, 16'h0000);
      wr(ADDR_PERIOD, 16'h0007);
      wr(ADDR_CONTROL, 16'h8000 | 16'(k << 2));
      wait_cnt(15'h0001, 1'b0);
      n = 0;
      while (count_q === 15'h0001 && n < 100)
      begin
        @(posedge ref_clk_in);
        #1;
        n++;
      end
      chk("prescale spacing", 16'(1 << (2 * k)), 16'(n));
    end
  endtask : t_presc

  // Up/down sequence, then which turning points raise the flag by mode.
  task automatic t_updown(input logic [1:0] mode, input logic [3:0] ops);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_CONTROL, {8'h80, ops, 2'b00, mode});
    wait_cnt(15'h0001, 1'b0);
    step_chk(15'h0002, 1'b0);
    step_chk(15'h0003, 1'b0);
    step_chk(15'h0002, 1'b1);
    chk("period match", 16'h0001, {15'h0000, match_w});
    step_chk(15'h0001, 1'b1);
    step_chk(15'h0000, 1'b0);
    chk("count zero", 16'h0001, {15'h0000, zero_w});
    step_chk(15'h0001, 1'b0);
    chk("no match or zero", 16'h0000, {14'h0000, match_w, zero_w});
    // Slow steps give room to clear the flag between turning points.
    wr(ADDR_CONTROL, {8'h80, ops, 2'b11, mode});
    wait_cnt(15'h0003, 1'b0);
    wr(ADDR_INT_STATUS, 16'h0001);
    rd_chk("status before turn", ADDR_INT_STATUS, 16'h0000);
    wait_cnt(15'h0002, 1'b1);
    rd_chk("status at turn", ADDR_INT_STATUS, {15'h0000, mode == 2'h3});
    wr(ADDR_INT_STATUS, 16'h0001);
    wait_cnt(15'h0000, 1'b0);
    rd_chk("status at zero", ADDR_INT_STATUS, 16'h0001);
  endtask : t_updown

  // Postscale 1:3 lets only every third wrap through.
  task automatic t_post();
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_CONTROL, 16'h802c);
    // Each wait aims at a value other than the present one, so every call really advances.
    wait_cnt(15'h0002, 1'b0);
    wait_cnt(15'h0001, 1'b0);
    wait_cnt(15'h0003, 1'b0);
    wait_cnt(15'h0001, 1'b0);
    wait_cnt(15'h0002, 1'b0);
    rd_chk("status after two wraps", ADDR_INT_STATUS, 16'h0000);
    wait_cnt(15'h0001, 1'b0);
    rd_chk("status after three", ADDR_INT_STATUS, 16'h0001);
  endtask : t_post

  // A zero period stops counting and blocks new periods until disabled.
  task automatic t_zero();
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_INT_STATUS, 16'h0001);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_PERIOD, 16'h0000);
    wr(ADDR_CONTROL, 16'h8003);
    repeat (20) @(posedge ref_clk_in);
    wr(ADDR_PERIOD, 16'h0005);
    repeat (20) @(posedge ref_clk_in);
    chk("count stopped", 16'h0000, {dir_q, count_q});
    rd_chk("no event", ADDR_INT_STATUS, 16'h0000);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h8000);
    wait_cnt(15'h0005, 1'b0);
  endtask : t_zero

  // ----------------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------------
  task automatic results();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Reset is held for five edges, then every scenario runs once, the up/down one once for each of its two modes.
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_free();
    t_single();
    t_presc();
    t_updown(2'h2, 4'h0);
    t_updown(2'h3, 4'hf);
    t_post();
    t_zero();
    results();
  end

  // The whole run takes a few thousand cycles, so this limit means a hang.
  initial
  begin
    #(20 * 40000);
    failures++;
    results();
  end

endmodule : testbench
